// File: sim/hst_upstream.sv
// Model of the upstream adder level driving hit sum and OR lines
`timescale 1ns/100ps
`default_nettype none
module hst_upstream (
    input wire logic clk,
    input wire logic [7:0] val,
    output logic [7:0] sum,
    output logic [15:0] or_lines
);
    always_ff @(posedge clk) begin
        sum <= val;
    end
    assign or_lines = {16{|sum}};
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the hit-sum trigger supervisor
`timescale 1ns/100ps
`default_nettype none
module tb import hst_pkg::*;;
    logic clk = 0, rst = 1, ext = 0, inh = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [7:0] val = 0, awa = 0, ara = 0, lo = 0, hi = 0, v, sum, wid = 8'h02;
    logic [15:0] orl, evn;
    logic [31:0] wd = 0, rdd, w;
    logic trg, gate, trst, irq, awr, wrr, bv, arr, rv;
    logic [1:0] br, rr;
    logic [3:0] dj = 0, dly = 4'h3;
    logic trg_q = 0, gate_q = 0;
    int bad_count = 0, total_checks = 0, ev = 0;
    int ntrg = 0, ngate = 0, ntrgc = 0, ntrst = 0;
    hst_upstream i_hst_upstream (.clk(clk), .val(val), .sum(sum), .or_lines(orl));
    hst_supervisor i_hst_supervisor (.SYS_CLK(clk), .RST(rst), .HIT_SUM(sum), .CRATE_OR(orl),
        .EXT_TRIGGER(ext), .INHIBIT_INPUT(inh), .DEAD_JUMPER(dj), .TRIGGER_OUT(trg),
        .GATE_OUT(gate), .EVENT_NUM(evn), .TIME_RESET_OUT(trst), .IRQ(irq),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bre), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rdd),
        .S_AXI_RRESP(rr));
    // ========
    // Tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrr) wv <= 0;
        end while (!bv);
        chk(br, r);
        bre <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ara <= a;
        arv <= 1;
        rre <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        d = rdd;
        rre <= 0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [7:0] p);
        val <= p;
        repeat (8) @(posedge clk);
        val <= 0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rec(input logic [3:0] k, input int n);
        repeat (90) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rd(OFS_FIFO_DATA, w);
            chk(w[31:28], TAG_MARK);
        end
        if (n > 0) begin
            rd(OFS_FIFO_DATA, w);
            chk(w, {TRAIL_MARK, dly, wid, hi, lo});
            rd(OFS_FIFO_DATA, w);
            chk(w, {TRAIL_MARK, k, 8'(n), 16'(ev)});
            ev++;
        end
        rd(OFS_CONTROL_STATUS, w);
        chk(w[CS_EMPTY], 1'b1);
        chk(evn, 16'(ev));
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ========
    // Sequence
    initial forever #20 clk = ~clk;
    // Output monitor: trigger and gate edges, trigger length, time-reset pulses
    always @(posedge clk) begin
        if (!rst) begin
            ntrg += int'(trg && !trg_q);
            ngate += int'(gate && !gate_q);
            ntrgc += int'(trg);
            ntrst += int'(trst);
        end
        trg_q <= trg;
        gate_q <= gate;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        void'($urandom(28));
        repeat (16) @(posedge clk);
        rst <= 0;
        dj <= 4'($urandom);
        @(posedge clk);
        wr(OFS_LUT, 32'h0001_FFFF, RESP_OKAY);
        wr(OFS_LUT, 32'h0000_0000, RESP_OKAY);
        wr(OFS_TIMING, {20'h0_0000, dly, wid}, RESP_OKAY);
        wr(8'h40, 32'h0000_0000, RESP_SLVERR);
        lo = 8'h05;
        for (int c = 0; c < 5; c++) begin
            hi = c < 4 ? 8'h0A : 8'h00;
            v = c == 0 ? 8'h04 : c == 1 ? 8'(5 + $urandom % 6) : c == 2 ? 8'h0B : 8'h0A;
            if (c == 4) v = 8'hC8;
            wr(OFS_THRESH, {16'h0000, hi, lo}, RESP_OKAY);
            pulse(v);
            rec(KIND_NORMAL, (c == 0 || c == 2) ? 0 : 1);
        end
        wr(OFS_LUT, 32'h0000_FFFF, RESP_OKAY);
        pulse(8'h07);
        rec(KIND_NORMAL, 0);
        wr(OFS_LUT, 32'h0001_FFFF, RESP_OKAY);
        pulse(8'h07);
        pulse(8'h07);
        rec(KIND_NORMAL, 2);
        wr(OFS_CONTROL_STATUS, 32'h0000_0018, RESP_OKAY);
        chk(irq, 1'b0);
        ext <= 1;
        repeat (4) @(posedge clk);
        ext <= 0;
        rec(KIND_EXTERNAL, 1);
        chk(irq, 1'b1);
        wr(OFS_CONTROL_STATUS, 32'h0000_0009, RESP_OKAY);
        rec(KIND_SOFTWARE, 1);
        inh <= 1;
        pulse(8'h07);
        repeat (10) @(posedge clk);
        inh <= 0;
        rec(KIND_NORMAL, 0);
        chk(ntrg, ev);
        chk(ngate, ev);
        chk(ntrgc, ev * TICK_CYCLES);
        wr(OFS_CONTROL_STATUS, 32'h0000_0016, RESP_OKAY);
        chk(evn, 16'h0000);
        chk(irq, 1'b0);
        chk(ntrst, 1);
        rd(OFS_TIME, w);
        chk(w < 32'd20, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire

// File: src/hst_mem.sv
// Single-port-write, registered-read memory
`timescale 1ns/100ps
`default_nettype none
module hst_mem #(
    parameter int DW = 32,
    parameter int AW = 12
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    generate
        if (DW < 1 || AW < 1 || AW > 16) begin : g_bad
            $error("hst_mem: unsupported size");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// File: src/hst_pkg.sv
// Shared constants and types of the hit-sum trigger supervisor
package hst_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 400;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);
    localparam int SUM_W = 8;
    localparam int TIME_W = 28;
    localparam int DLY_STAGES = 16;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_TIMING = 8'h08;
    localparam logic [7:0] OFS_FIFO_DATA = 8'h0C;
    localparam logic [7:0] OFS_EVENT = 8'h10;
    localparam logic [7:0] OFS_TIME = 8'h14;
    localparam logic [7:0] OFS_LUT = 8'h18;
    localparam logic [7:0] OFS_FIFO_COUNT = 8'h1C;
    // ==========================================================
    // Control/status bit positions
    localparam int CS_SW_TRIG = 0;
    localparam int CS_CLR_EVENT = 1;
    localparam int CS_RST_TIME = 2;
    localparam int CS_IRQ_EN = 3;
    localparam int CS_IRQ_CLR = 4;
    localparam int CS_IRQ_PEND = 4;
    localparam int CS_EMPTY = 8;
    localparam int CS_HALF = 9;
    localparam int CS_FULL = 10;
    localparam int CS_GATE = 11;
    localparam int LUT_DATA_BIT = 16;
    // ==========================================================
    // Reset values and record codes
    localparam logic [15:0] THRESH_RESET = 16'h0001;
    localparam logic [11:0] TIMING_RESET = 12'h001;
    localparam logic [3:0] TAG_MARK = 4'h0;
    localparam logic [3:0] TRAIL_MARK = 4'hF;
    localparam logic [3:0] KIND_NORMAL = 4'h1;
    localparam logic [3:0] KIND_EXTERNAL = 4'h2;
    localparam logic [3:0] KIND_SOFTWARE = 4'h3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_SETTINGS, ST_TRAILER} hst_state_type;
endpackage

// File: src/hst_supervisor.sv
// Hit-sum trigger supervisor with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
module hst_supervisor
    import hst_pkg::*;
#(
    parameter int FIFO_AW = 12,
    parameter int OR_W = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [SUM_W-1:0] HIT_SUM,
    input wire logic [OR_W-1:0] CRATE_OR,
    input wire logic EXT_TRIGGER,
    input wire logic INHIBIT_INPUT,
    input wire logic [3:0] DEAD_JUMPER,
    output logic TRIGGER_OUT,
    output logic GATE_OUT,
    output logic [15:0] EVENT_NUM,
    output logic TIME_RESET_OUT,
    output logic IRQ,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP
);
    generate
        if (FIFO_AW < 2 || FIFO_AW > 16 || OR_W < 1 || OR_W > 16) begin : g_bad
            $error("hst_supervisor: unsupported parameter");
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Input synchronisers and OR-line delay
    logic [SUM_W-1:0] sum_s1_q, sum_s2_q, sum_a_q;
    logic [OR_W-1:0] or_s1_q, or_s2_q, or_d1_q, or_d2_q, or_d3_q;
    logic [1:0] ext_s_q, inh_s_q;
    logic ext_prev_q;
    logic [3:0] jmp_s1_q, jmp_s2_q;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sum_s1_q <= '0;
            sum_s2_q <= '0;
            sum_a_q <= '0;
            or_s1_q <= '0;
            or_s2_q <= '0;
            ext_s_q <= '0;
            inh_s_q <= '0;
            ext_prev_q <= 1'b0;
            jmp_s1_q <= '0;
            jmp_s2_q <= '0;
        end else begin
            sum_s1_q <= HIT_SUM;
            sum_s2_q <= sum_s1_q;
            sum_a_q <= sum_s2_q;
            or_s1_q <= CRATE_OR;
            or_s2_q <= or_s1_q;
            ext_s_q <= {ext_s_q[0], EXT_TRIGGER};
            inh_s_q <= {inh_s_q[0], INHIBIT_INPUT};
            ext_prev_q <= ext_s_q[1];
            jmp_s1_q <= DEAD_JUMPER;
            jmp_s2_q <= jmp_s1_q;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            or_d1_q <= '0;
            or_d2_q <= '0;
            or_d3_q <= '0;
        end else begin
            or_d1_q <= or_s2_q;
            or_d2_q <= or_d1_q;
            or_d3_q <= or_d2_q;
        end
    end

    // ==========================================================
    // Registers and shared signals
    logic [15:0] thresh_q;
    logic [11:0] timing_q;
    logic irq_en_q, irq_pend_q;
    logic [7:0] low_q, high_q, width_q;
    logic [3:0] delay_q;
    logic wr_fire, rd_take;
    logic [7:0] awaddr_q, araddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic cs_wr, sw_evt, clr_evt, rst_time, lut_we;
    hst_state_type state_q;
    logic [3:0] tick_cnt_q, dead_q;
    logic tick, lut_ok, win_ok, cond_now, cond_prev_q;
    logic norm_evt, ext_evt, any_evt, fire, extend;
    logic [15:0] remain_q, remain_d, event_q, ev_snap_q;
    logic [TIME_W-1:0] time_q;
    logic [7:0] ntag_q;
    logic [3:0] kind_q;
    logic [27:0] snap_q;

    assign low_q = thresh_q[7:0];
    assign high_q = thresh_q[15:8];
    assign width_q = timing_q[7:0];
    assign delay_q = timing_q[11:8];
    assign cs_wr = wr_fire && awaddr_q == OFS_CONTROL_STATUS && wstrb_q[0];
    assign sw_evt = cs_wr && wdata_q[CS_SW_TRIG];
    assign clr_evt = cs_wr && wdata_q[CS_CLR_EVENT];
    assign rst_time = cs_wr && wdata_q[CS_RST_TIME];
    assign lut_we = wr_fire && awaddr_q == OFS_LUT;

    // ==========================================================
    // Topology table and trigger condition
    hst_mem #(.DW(1), .AW(OR_W)) u_lut (
        .clk(SYS_CLK),
        .we(lut_we),
        .waddr(wdata_q[OR_W-1:0]),
        .wdata(wdata_q[LUT_DATA_BIT]),
        .raddr(or_d3_q),
        .rdata(lut_ok)
    );

    assign win_ok = sum_a_q >= low_q && (high_q == 8'h00 || sum_a_q <= high_q);
    assign cond_now = win_ok && lut_ok;
    assign norm_evt = cond_now && !cond_prev_q;
    assign ext_evt = ext_s_q[1] && !ext_prev_q;
    assign any_evt = (norm_evt || ext_evt || sw_evt) && !inh_s_q[1];
    assign fire = state_q == ST_IDLE && any_evt && dead_q == 4'h0;
    assign extend = state_q == ST_OPEN && any_evt;
    assign tick = tick_cnt_q == TICK_LAST;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tick_cnt_q <= '0;
            cond_prev_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick ? 4'h0 : tick_cnt_q + 4'h1;
            cond_prev_q <= cond_now;
        end
    end

    // ==========================================================
    // Acquisition window sequencer
    always_comb begin
        remain_d = remain_q;
        if (fire) begin
            remain_d = {8'h00, width_q};
        end else if (state_q == ST_OPEN) begin
            if (tick && remain_q != 16'h0000) begin
                remain_d = remain_q - 16'h0001;
            end
            if (extend) begin
                remain_d = remain_d + {8'h00, width_q};
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            remain_q <= '0;
            dead_q <= '0;
        end else begin
            remain_q <= remain_d;
            if (dead_q != 4'h0) begin
                dead_q <= dead_q - 4'h1;
            end
            unique case (state_q)
                ST_IDLE: begin
                    if (fire) begin
                        state_q <= ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    if (remain_q == 16'h0000 && !extend) begin
                        state_q <= ST_SETTINGS;
                    end
                end
                ST_SETTINGS: begin
                    state_q <= ST_TRAILER;
                end
                ST_TRAILER: begin
                    state_q <= ST_IDLE;
                    dead_q <= jmp_s2_q;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ntag_q <= '0;
            kind_q <= '0;
            snap_q <= '0;
            ev_snap_q <= '0;
        end else if (fire) begin
            ntag_q <= 8'h01;
            kind_q <= norm_evt ? KIND_NORMAL : ext_evt ? KIND_EXTERNAL : KIND_SOFTWARE;
            snap_q <= {delay_q, width_q, high_q, low_q};
            ev_snap_q <= event_q;
        end else if (extend && ntag_q != 8'hFF) begin
            ntag_q <= ntag_q + 8'h01;
        end
    end

    // ==========================================================
    // Event number, time counter, interrupt
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            event_q <= '0;
        end else if (clr_evt) begin
            event_q <= fire ? 16'h0001 : 16'h0000;
        end else if (fire) begin
            event_q <= event_q + 16'h0001;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            time_q <= '0;
            TIME_RESET_OUT <= 1'b0;
        end else begin
            time_q <= rst_time ? '0 : time_q + 28'h000_0001;
            TIME_RESET_OUT <= rst_time;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_en_q <= 1'b0;
            irq_pend_q <= 1'b0;
        end else begin
            if (cs_wr) begin
                irq_en_q <= wdata_q[CS_IRQ_EN];
            end
            if (fire) begin
                irq_pend_q <= 1'b1;
            end else if (cs_wr && wdata_q[CS_IRQ_CLR]) begin
                irq_pend_q <= 1'b0;
            end
        end
    end

    assign IRQ = irq_pend_q && irq_en_q;
    assign EVENT_NUM = event_q;

    // ==========================================================
    // Output delay line at tick rate
    logic [1:0] stage_q [DLY_STAGES];
    logic trig_hold_q;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            trig_hold_q <= 1'b0;
            TRIGGER_OUT <= 1'b0;
            GATE_OUT <= 1'b0;
            for (int i = 0; i < DLY_STAGES; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            if (tick) begin
                trig_hold_q <= 1'b0;
            end else if (fire) begin
                trig_hold_q <= 1'b1;
            end
            if (tick) begin
                stage_q[0] <= {state_q == ST_OPEN || fire, trig_hold_q || fire};
                for (int i = 1; i < DLY_STAGES; i++) begin
                    stage_q[i] <= stage_q[i-1];
                end
            end
            TRIGGER_OUT <= stage_q[delay_q][0];
            GATE_OUT <= stage_q[delay_q][1];
        end
    end

    // ==========================================================
    // Record FIFO
    logic [FIFO_AW:0] wr_ptr_q, rd_ptr_q, fcount;
    logic fifo_we, f_empty, f_half, f_full, pop;
    logic [31:0] fifo_wd, fifo_rd;

    assign fcount = wr_ptr_q - rd_ptr_q;
    assign f_full = fcount[FIFO_AW];
    assign f_half = fcount[FIFO_AW] || fcount[FIFO_AW-1];
    assign f_empty = fcount == '0;
    assign fifo_we = (fire || extend || state_q == ST_SETTINGS || state_q == ST_TRAILER)
                     && !f_full;
    assign pop = rd_take && S_AXI_ARADDR == OFS_FIFO_DATA && !f_empty;

    always_comb begin
        unique case (state_q)
            ST_SETTINGS: fifo_wd = {TRAIL_MARK, snap_q};
            ST_TRAILER: fifo_wd = {TRAIL_MARK, kind_q, ntag_q, ev_snap_q};
            default: fifo_wd = {TAG_MARK, time_q};
        endcase
    end

    hst_mem #(.DW(32), .AW(FIFO_AW)) u_fifo (
        .clk(SYS_CLK),
        .we(fifo_we),
        .waddr(wr_ptr_q[FIFO_AW-1:0]),
        .wdata(fifo_wd),
        .raddr(rd_ptr_q[FIFO_AW-1:0]),
        .rdata(fifo_rd)
    );

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (fifo_we) begin
                wr_ptr_q <= wr_ptr_q + {{FIFO_AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{FIFO_AW{1'b0}}, 1'b1};
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_hold_q, w_hold_q, ar_hold_q, popped_q;

    assign S_AXI_AWREADY = !aw_hold_q && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_hold_q && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !ar_hold_q && !S_AXI_RVALID;
    assign wr_fire = aw_hold_q && w_hold_q;
    assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (awaddr_q[7:5] == 3'b000 && awaddr_q[1:0] == 2'b00)
                               ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    logic [31:0] thresh_m, timing_m;

    assign thresh_m = merge({16'h0000, thresh_q}, wdata_q, wstrb_q);
    assign timing_m = merge({20'h0_0000, timing_q}, wdata_q, wstrb_q);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            thresh_q <= THRESH_RESET;
            timing_q <= TIMING_RESET;
        end else if (wr_fire && awaddr_q == OFS_THRESH) begin
            thresh_q <= thresh_m[15:0];
        end else if (wr_fire && awaddr_q == OFS_TIMING) begin
            timing_q <= timing_m[11:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ar_hold_q <= 1'b0;
            araddr_q <= '0;
            popped_q <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            if (rd_take) begin
                ar_hold_q <= 1'b1;
                araddr_q <= S_AXI_ARADDR;
                popped_q <= pop;
            end
            if (ar_hold_q) begin
                ar_hold_q <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= RESP_OKAY;
                S_AXI_RDATA <= '0;
                case (araddr_q)
                    OFS_CONTROL_STATUS: begin
                        S_AXI_RDATA[CS_IRQ_EN] <= irq_en_q;
                        S_AXI_RDATA[CS_IRQ_PEND] <= irq_pend_q;
                        S_AXI_RDATA[CS_EMPTY] <= f_empty;
                        S_AXI_RDATA[CS_HALF] <= f_half;
                        S_AXI_RDATA[CS_FULL] <= f_full;
                        S_AXI_RDATA[CS_GATE] <= state_q == ST_OPEN;
                    end
                    OFS_THRESH: S_AXI_RDATA[15:0] <= thresh_q;
                    OFS_TIMING: S_AXI_RDATA[11:0] <= timing_q;
                    OFS_FIFO_DATA: S_AXI_RDATA <= popped_q ? fifo_rd : 32'h0000_0000;
                    OFS_EVENT: S_AXI_RDATA[15:0] <= event_q;
                    OFS_TIME: S_AXI_RDATA[TIME_W-1:0] <= time_q;
                    OFS_LUT: S_AXI_RDATA <= 32'h0000_0000;
                    OFS_FIFO_COUNT: S_AXI_RDATA[FIFO_AW:0] <= fcount;
                    default: S_AXI_RRESP <= RESP_SLVERR;
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_close;
        state_q == ST_SETTINGS ##1 state_q == ST_TRAILER ##1 state_q == ST_IDLE;
    endsequence

    a_window_floor: assert property (norm_evt |-> sum_a_q >= low_q && lut_ok)
        else $error("trigger condition outside lower threshold or table");
    a_upper_off: assert property (high_q == 8'h00 && sum_a_q >= low_q && lut_ok |-> cond_now)
        else $error("zero upper threshold still limits the window");
    a_gate_close: assert property (state_q == ST_OPEN && remain_q == 16'h0000 && !extend
        |=> s_close) else $error("window close sequence broken");
    // Cycles since the last tick, saturating
    logic [3:0] tick_gap_q;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tick_gap_q <= '0;
        end else if (tick) begin
            tick_gap_q <= '0;
        end else if (tick_gap_q != 4'hF) begin
            tick_gap_q <= tick_gap_q + 4'h1;
        end
    end

    a_tick_period: assert property (tick |-> tick_gap_q == TICK_LAST)
        else $error("tick period wrong");
    a_extend_adds: assert property (extend && !tick |=> remain_q == $past(remain_q)
        + {8'h00, $past(width_q)}) else $error("extension did not add duration");
    a_no_retrig: assert property (state_q == ST_OPEN && any_evt |=> !trig_hold_q || $past(trig_hold_q))
        else $error("retrigger during open window");
    a_event_inc: assert property (fire && !clr_evt |=> EVENT_NUM == $past(EVENT_NUM) + 16'h0001)
        else $error("event number not incremented");
    a_time_reset: assert property (rst_time |=> TIME_RESET_OUT && time_q == '0)
        else $error("time reset not applied");
    a_tag_marks: assert property (fifo_we |-> fifo_wd[31:28] ==
        ((state_q == ST_SETTINGS || state_q == ST_TRAILER) ? TRAIL_MARK : TAG_MARK))
        else $error("record marker nibble wrong");
    a_inhibit: assert property (inh_s_q[1] |-> !fire && !extend)
        else $error("trigger while inhibited");
    a_dead_time: assert property (state_q == ST_TRAILER && jmp_s2_q != 4'h0 |=> !fire)
        else $error("trigger inside dead time");
    a_irq_raise: assert property (fire && irq_en_q && !cs_wr |=> IRQ)
        else $error("interrupt not raised");
endmodule
`default_nettype wire
